// File: alu_pkg.sv
// package: constants, opcodes and flag positions for the arithmetic and io access unit
package alu_pkg;
	localparam int DW = 8;
	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	// io space
	localparam logic [5:0] IO_LAST = 6'h3f;
	localparam logic [5:0] IO_BIT_LAST = 6'h1f;
	localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
	localparam int WORD_CYCLES = 2;
	localparam int BYTE_CYCLES = 1;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD,
		OP_ADD_CARRY,
		OP_WORD_ADD_IMMEDIATE,
		OP_SUB,
		OP_SUBTRACT_WITH_CARRY,
		OP_WORD_SUBTRACT_IMMEDIATE,
		OP_AND,
		OP_OR
	} alu_op_t;

	typedef enum logic [3:0] {
		IO_NONE,
		IO_IN,
		IO_OUT,
		IO_BIT_SET,
		IO_BIT_CLEAR,
		IO_SKIP_IF_SET,
		IO_SKIP_IF_CLEAR,
		IO_DATA_SPACE_LOAD,
		IO_DATA_SPACE_STORE
	} alu_io_op_t;
endpackage

// File: alu_if.sv
// interface: bundle between the top and its arithmetic core
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
	alu_pkg::alu_op_t opcode;
	logic [7:0]       opA;
	logic [7:0]       opB;
	logic             carryIn;
	logic [7:0]       result;
	logic [5:0]       flagsSet;
	logic [5:0]       flagsMask;
	logic             carryOut;
	modport core (input opcode, opA, opB, carryIn, output result, flagsSet, flagsMask, carryOut);
	modport user (output opcode, opA, opB, carryIn, input result, flagsSet, flagsMask, carryOut);
endinterface
`default_nettype wire

// File: alu_core.sv
// module: combinational byte arithmetic and logic with flag production
`timescale 1ns/1ps
`default_nettype none
module alu_core (
	alu_if.core bus
);
	logic [8:0] sum;
	logic [4:0] half;
	logic       isSub;
	logic       useC;
	logic [7:0] r;
	always_comb begin
		isSub = 1'b0;
		useC = 1'b0;
		sum = 9'h000;
		half = 5'h00;
		r = 8'h00;
		bus.flagsMask = 6'h00;
		case (bus.opcode)
			alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY, alu_pkg::OP_WORD_ADD_IMMEDIATE: begin
				useC = (bus.opcode != alu_pkg::OP_ADD);
				sum = {1'b0, bus.opA} + {1'b0, bus.opB} + {8'h00, useC & bus.carryIn};
				half = {1'b0, bus.opA[3:0]} + {1'b0, bus.opB[3:0]} + {4'h0, useC & bus.carryIn};
				r = sum[7:0];
				bus.flagsMask = 6'h2f;
			end
			alu_pkg::OP_SUB, alu_pkg::OP_SUBTRACT_WITH_CARRY,
			alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
				isSub = 1'b1;
				useC = (bus.opcode != alu_pkg::OP_SUB);
				sum = {1'b0, bus.opA} - {1'b0, bus.opB} - {8'h00, useC & bus.carryIn};
				half = {1'b0, bus.opA[3:0]} - {1'b0, bus.opB[3:0]} - {4'h0, useC & bus.carryIn};
				r = sum[7:0];
				bus.flagsMask = 6'h2f;
			end
			alu_pkg::OP_AND: begin
				r = bus.opA & bus.opB;
				bus.flagsMask = 6'h0e;
			end
			alu_pkg::OP_OR: begin
				r = bus.opA | bus.opB;
				bus.flagsMask = 6'h0e;
			end
			default: begin
				r = 8'h00;
			end
		endcase
		bus.result = r;
		bus.carryOut = sum[8];
		bus.flagsSet = 6'h00;
		bus.flagsSet[alu_pkg::FLAG_C] = sum[8];
		bus.flagsSet[alu_pkg::FLAG_Z] = (r == 8'h00);
		bus.flagsSet[alu_pkg::FLAG_N] = r[7];
		if (isSub) begin
			bus.flagsSet[alu_pkg::FLAG_V] = (bus.opA[7] ^ bus.opB[7]) & (bus.opA[7] ^ r[7]);
		end else if (bus.flagsMask[alu_pkg::FLAG_C]) begin
			bus.flagsSet[alu_pkg::FLAG_V] = ~(bus.opA[7] ^ bus.opB[7]) & (bus.opA[7] ^ r[7]);
		end
		bus.flagsSet[alu_pkg::FLAG_S] = r[7] ^ bus.flagsSet[alu_pkg::FLAG_V];
		bus.flagsSet[alu_pkg::FLAG_H] = half[4];
	end
endmodule
`default_nettype wire

// File: alu_io_map.sv
// module: io address decode for direct, bit and data space access
`timescale 1ns/1ps
`default_nettype none
module alu_io_map (
	input  wire alu_pkg::alu_io_op_t ioOp,
	input  wire logic [7:0]          ioAddr,
	output logic [5:0]               ioIndex,
	output logic                     ioLegal
);
	always_comb begin
		ioIndex = ioAddr[5:0];
		ioLegal = 1'b0;
		case (ioOp)
			alu_pkg::IO_IN, alu_pkg::IO_OUT: begin
				ioLegal = (ioAddr <= {2'b00, alu_pkg::IO_LAST});
			end
			alu_pkg::IO_BIT_SET, alu_pkg::IO_BIT_CLEAR,
			alu_pkg::IO_SKIP_IF_SET, alu_pkg::IO_SKIP_IF_CLEAR: begin
				ioLegal = (ioAddr <= {2'b00, alu_pkg::IO_BIT_LAST});
			end
			alu_pkg::IO_DATA_SPACE_LOAD, alu_pkg::IO_DATA_SPACE_STORE: begin
				ioIndex = 6'(ioAddr - alu_pkg::IO_DATA_OFFSET);
				ioLegal = (ioAddr >= alu_pkg::IO_DATA_OFFSET)
					&& (ioAddr <= (alu_pkg::IO_DATA_OFFSET + {2'b00, alu_pkg::IO_LAST}));
			end
			default: begin
				ioLegal = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// File: alu_unit.sv
// top: arithmetic/logic execution and io register access of an 8-bit core
// Contract
// - add registers, optional carry, five flags, one cycle
// - word add immediate to pair, two cycles
// - subtract register or constant, one cycle
// - register subtract with carry, one cycle
// - constant subtract with carry, one cycle
// - word subtract immediate from pair, two cycles
// - and with register or constant, Z N V
// - or with register or constant, Z N V
// - bit set/clear/skip only at io 0x00-0x1f
// - some flags cleared by writing one
// - bit set/clear touches only addressed bit
// - direct io uses offsets 0x00-0x3f
// - data space io address is offset plus 0x20
`timescale 1ns/1ps
`default_nettype none
module alu_unit #(
	parameter int IO_REGS = 64
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                opValid,
	input  wire alu_pkg::alu_op_t    opCode,
	input  wire logic [7:0]          opDest,
	input  wire logic [7:0]          opSrc,
	input  wire logic [7:0]          opDestHigh,
	input  wire logic                ioValid,
	input  wire alu_pkg::alu_io_op_t ioOp,
	input  wire logic [7:0]          ioAddr,
	input  wire logic [2:0]          ioBit,
	input  wire logic [7:0]          ioWrData,
	input  wire logic [7:0]          ioW1cMask,
	input  wire logic [7:0]          ioHwSet,
	input  wire logic [5:0]          ioHwSetIndex,
	output logic                     busy,
	output logic                     resValid,
	output logic [7:0]               resLow,
	output logic [7:0]               resHigh,
	output logic                     resWord,
	output logic [5:0]               flags,
	output logic [7:0]               ioRdData,
	output logic                     ioSkip,
	output logic                     ioError
);
	typedef struct packed {
		logic                busy;
		logic                resValid;
		logic [7:0]          resLow;
		logic [7:0]          resHigh;
		logic                resWord;
		logic [5:0]          flags;
		logic [7:0]          ioRdData;
		logic                ioSkip;
		logic                ioError;
		logic [7:0]          wordHigh;
		logic                wordSub;
		logic                wordCarry;
		logic [7:0]          wordLow;
		logic [7:0]          wordLowSrc;
		logic [7:0]          wordImm;
	} alu_state_t;

	alu_state_t st_reg;
	alu_state_t st_next;
	logic [7:0] ioMem_reg [IO_REGS];
	alu_if      coreBus ();
	logic [5:0] ioIndex;
	logic       ioLegal;
	logic       ioWrite;
	logic [7:0] ioNewVal;
	logic [7:0] ioCur;
	logic [8:0] highSum;
	logic [7:0] highRes;

	////////////////////////////////////////////////////////////////
	alu_core u_core (
		.bus (coreBus)
	);

	alu_io_map u_map (
		.ioOp    (ioOp),
		.ioAddr  (ioAddr),
		.ioIndex (ioIndex),
		.ioLegal (ioLegal)
	);

	////////////////////////////////////////////////////////////////
	always_comb begin
		coreBus.opcode = opValid && !st_reg.busy ? opCode : alu_pkg::OP_NONE;
		coreBus.opA = opDest;
		coreBus.opB = opSrc;
		coreBus.carryIn = st_reg.flags[alu_pkg::FLAG_C];
		// word ops second cycle: high byte with carry/borrow from low
		if (st_reg.wordSub) begin
			highSum = {1'b0, st_reg.wordHigh} - {8'h00, st_reg.wordCarry};
		end else begin
			highSum = {1'b0, st_reg.wordHigh} + {8'h00, st_reg.wordCarry};
		end
		highRes = highSum[7:0];
	end

	always_comb begin
		ioCur = ioMem_reg[ioIndex];
		ioWrite = 1'b0;
		ioNewVal = ioCur;
		if (ioValid && ioLegal) begin
			case (ioOp)
				alu_pkg::IO_OUT, alu_pkg::IO_DATA_SPACE_STORE: begin
					ioWrite = 1'b1;
					// flagged bits clear on one, keep on zero
					ioNewVal = (ioWrData & ~ioW1cMask) | (ioCur & ioW1cMask & ~ioWrData);
				end
				alu_pkg::IO_BIT_SET: begin
					ioWrite = 1'b1;
					ioNewVal = ioCur | (8'h01 << ioBit);
				end
				alu_pkg::IO_BIT_CLEAR: begin
					ioWrite = 1'b1;
					ioNewVal = ioCur & ~(8'h01 << ioBit);
				end
				default: begin
					ioWrite = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		st_next.resValid = 1'b0;
		st_next.ioSkip = 1'b0;
		st_next.ioError = 1'b0;
		st_next.resWord = 1'b0;
		if (st_reg.busy) begin
			// second cycle of the word operation
			st_next.busy = 1'b0;
			st_next.resValid = 1'b1;
			st_next.resWord = 1'b1;
			st_next.resLow = st_reg.wordLow;
			st_next.resHigh = highRes;
			st_next.flags[alu_pkg::FLAG_Z] = ({highRes, st_reg.wordLow} == 16'h0000);
			st_next.flags[alu_pkg::FLAG_N] = highRes[7];
			st_next.flags[alu_pkg::FLAG_C] = st_reg.wordSub ? (highRes[7] & ~st_reg.wordHigh[7])
				: (~highRes[7] & st_reg.wordHigh[7]);
			st_next.flags[alu_pkg::FLAG_V] = st_reg.wordSub ? (st_reg.wordHigh[7] & ~highRes[7])
				: (~st_reg.wordHigh[7] & highRes[7]);
			st_next.flags[alu_pkg::FLAG_S] = highRes[7]
				^ (st_reg.wordSub ? (st_reg.wordHigh[7] & ~highRes[7])
				: (~st_reg.wordHigh[7] & highRes[7]));
		end else if (opValid) begin
			case (opCode)
				alu_pkg::OP_WORD_ADD_IMMEDIATE, alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
					st_next.busy = 1'b1;
					st_next.wordSub = (opCode == alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE);
					st_next.wordHigh = opDestHigh;
					st_next.wordLow = opCode == alu_pkg::OP_WORD_ADD_IMMEDIATE
						? 8'(opDest + opSrc) : 8'(opDest - opSrc);
					st_next.wordCarry = opCode == alu_pkg::OP_WORD_ADD_IMMEDIATE
						? ({1'b0, opDest} + {1'b0, opSrc}) > 9'h0ff : (opSrc > opDest);
				end
				alu_pkg::OP_NONE: begin
					st_next.resValid = 1'b0;
				end
				default: begin
					st_next.resValid = 1'b1;
					st_next.resLow = coreBus.result;
					// only listed flags change, rest held
					st_next.flags = (st_reg.flags & ~coreBus.flagsMask)
						| (coreBus.flagsSet & coreBus.flagsMask);
				end
			endcase
		end
		if (ioValid) begin
			st_next.ioError = !ioLegal;
			st_next.ioRdData = ioCur;
			if (ioLegal && ioOp == alu_pkg::IO_SKIP_IF_SET) begin
				st_next.ioSkip = ioCur[ioBit];
			end else if (ioLegal && ioOp == alu_pkg::IO_SKIP_IF_CLEAR) begin
				st_next.ioSkip = !ioCur[ioBit];
			end
		end
		if (srst) begin
			st_next = '0;
			st_next.flags = alu_pkg::FLAGS_RESET;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < IO_REGS; i++) begin
			if (srst) begin
				ioMem_reg[i] <= 8'h00;
			end else if (ioWrite && ioIndex == 6'(i)) begin
				ioMem_reg[i] <= ioNewVal | ((ioHwSetIndex == 6'(i)) ? ioHwSet : 8'h00);
			end else if (ioHwSetIndex == 6'(i)) begin
				ioMem_reg[i] <= ioMem_reg[i] | ioHwSet; // hardware set wins over clear
			end
		end
	end

	assign busy = st_reg.busy;
	assign resValid = st_reg.resValid;
	assign resLow = st_reg.resLow;
	assign resHigh = st_reg.resHigh;
	assign resWord = st_reg.resWord;
	assign flags = st_reg.flags;
	assign ioRdData = st_reg.ioRdData;
	assign ioSkip = st_reg.ioSkip;
	assign ioError = st_reg.ioError;
endmodule
`default_nettype wire

// File: alu_unit_assertions.sv
// checker: timing and value relations at the execution unit ports
`timescale 1ns/1ps
`default_nettype none
module alu_unit_assertions #(
	parameter int IO_REGS = 64
) (
	input wire logic                clk,
	input wire logic                srst,
	input wire logic                opValid,
	input wire alu_pkg::alu_op_t    opCode,
	input wire logic [7:0]          opDest,
	input wire logic [7:0]          opSrc,
	input wire logic                ioValid,
	input wire alu_pkg::alu_io_op_t ioOp,
	input wire logic [7:0]          ioAddr,
	input wire logic                busy,
	input wire logic                resValid,
	input wire logic [7:0]          resLow,
	input wire logic                resWord,
	input wire logic [5:0]          flags,
	input wire logic                ioError
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	wire logic take = opValid && !busy;
	wire logic isWord = opCode inside {alu_pkg::OP_WORD_ADD_IMMEDIATE,
		alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE};
	wire logic bitOp = ioValid && ioOp inside {[alu_pkg::IO_BIT_SET:alu_pkg::IO_SKIP_IF_CLEAR]};
	a_byte_one_cycle: assert property (
		take && opCode != alu_pkg::OP_NONE && !isWord |=> resValid && !resWord)
		else $error("byte result late");
	a_word_two_cycles: assert property (
		take && isWord |=> busy && !resValid ##1 resValid && resWord && !busy)
		else $error("word timing wrong");
	a_add_sum: assert property (
		take && opCode == alu_pkg::OP_ADD |=> resLow == 8'($past(opDest) + $past(opSrc)))
		else $error("sum wrong");
	a_sub_diff: assert property (
		take && opCode == alu_pkg::OP_SUB |=> resLow == 8'($past(opDest) - $past(opSrc)))
		else $error("difference wrong");
	a_and_value: assert property (
		take && opCode == alu_pkg::OP_AND
		|=> resLow == ($past(opDest) & $past(opSrc)) && !flags[3])
		else $error("and wrong");
	a_or_value: assert property (
		take && opCode == alu_pkg::OP_OR
		|=> resLow == ($past(opDest) | $past(opSrc)) && !flags[3])
		else $error("or wrong");
	a_logic_keeps_flags: assert property (
		take && opCode inside {alu_pkg::OP_AND, alu_pkg::OP_OR}
		|=> (flags & 6'h31) == ($past(flags) & 6'h31))
		else $error("logic op touched flags");
	a_word_keeps_h: assert property (
		take && isWord |=> ##1 flags[5] == $past(flags[5], 2))
		else $error("word op touched half carry");
	a_bit_range: assert property (
		bitOp && ioAddr > 8'h1f |=> ioError)
		else $error("bit op out of range");
	a_direct_range: assert property (
		ioValid && ioOp inside {alu_pkg::IO_IN, alu_pkg::IO_OUT}
		|=> ioError == ($past(ioAddr) > 8'h3f))
		else $error("direct range wrong");
	a_load_map: assert property (
		ioValid && ioOp inside {alu_pkg::IO_DATA_SPACE_LOAD, alu_pkg::IO_DATA_SPACE_STORE}
		|=> ioError == ($past(ioAddr) < 8'h20 || $past(ioAddr) > 8'h5f))
		else $error("data space map wrong");
endmodule
bind alu_unit alu_unit_assertions #(.IO_REGS(IO_REGS)) u_chk (.clk, .srst, .opValid, .opCode,
	.opDest, .opSrc, .ioValid, .ioOp, .ioAddr, .busy, .resValid, .resLow, .resWord, .flags,
	.ioError);
`default_nettype wire

// File: alu_io_env_model.sv
// partner: io neighbourhood giving clear masks and hardware flag sets
`timescale 1ns/1ps
`default_nettype none
module alu_io_env_model (
	input  wire logic [7:0] ioAddr,
	input  wire logic       hwPulse,
	output logic [7:0]      ioW1cMask,
	output logic [7:0]      ioHwSet,
	output logic [5:0]      ioHwSetIndex
);
	// bit 0 of register 0x05 is a flag cleared by a written one
	always_comb begin
		ioW1cMask = (ioAddr == 8'h05 || ioAddr == 8'h25) ? 8'h01 : 8'h00;
		ioHwSet = hwPulse ? 8'h01 : 8'h00;
		ioHwSetIndex = hwPulse ? 6'h05 : 6'h00;
	end
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench: arithmetic, flag and io access sequences
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                clk = 1'b0;
	logic                srst = 1'b1;
	logic                opValid = 1'b0;
	alu_pkg::alu_op_t    opCode = alu_pkg::OP_NONE;
	logic [7:0]          opDest = 8'h00;
	logic [7:0]          opSrc = 8'h00;
	logic [7:0]          opDestHigh = 8'h00;
	logic                ioValid = 1'b0;
	alu_pkg::alu_io_op_t ioOp = alu_pkg::IO_NONE;
	logic [7:0]          ioAddr = 8'h00;
	logic [2:0]          ioBit = 3'h0;
	logic [7:0]          ioWrData = 8'h00;
	logic                hwPulse = 1'b0;
	wire logic [7:0]     ioW1cMask, ioHwSet, resLow, resHigh, ioRdData;
	wire logic [5:0]     ioHwSetIndex, flags;
	wire logic           busy, resValid, resWord, ioSkip, ioError;
	logic [5:0]          fl = 6'h00;
	int                  failures = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	always #2.5 clk = ~clk;
	alu_unit dut (.clk, .srst, .opValid, .opCode, .opDest, .opSrc, .opDestHigh, .ioValid,
		.ioOp, .ioAddr, .ioBit, .ioWrData, .ioW1cMask, .ioHwSet, .ioHwSetIndex, .busy,
		.resValid, .resLow, .resHigh, .resWord, .flags, .ioRdData, .ioSkip, .ioError);
	alu_io_env_model env (.ioAddr, .hwPulse, .ioW1cMask, .ioHwSet, .ioHwSetIndex);
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(logic ok, string m);
		total_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// entered at a falling edge; request held until the next one replaces it
	task automatic op(alu_pkg::alu_op_t c, logic [7:0] d, logic [7:0] s, logic [7:0] h);
		logic [8:0]  r;
		logic [4:0]  hn;
		logic [16:0] w;
		logic        wd;
		logic        cin;
		wd = c inside {alu_pkg::OP_WORD_ADD_IMMEDIATE, alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE};
		cin = c inside {alu_pkg::OP_ADD_CARRY, alu_pkg::OP_SUBTRACT_WITH_CARRY} && fl[0];
		opValid = 1'b1;
		opCode = c;
		opDest = d;
		opSrc = s;
		opDestHigh = h;
		case (c)
			alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY: begin
				r = d + s + cin;
				hn = d[3:0] + s[3:0] + cin;
				fl[3] = d[7] == s[7] && r[7] != d[7];
			end
			alu_pkg::OP_SUB, alu_pkg::OP_SUBTRACT_WITH_CARRY: begin
				r = {1'b0, d} - s - cin;
				hn = {1'b0, d[3:0]} - s[3:0] - cin;
				fl[3] = d[7] != s[7] && r[7] != d[7];
			end
			alu_pkg::OP_AND: r = {1'b0, d & s};
			alu_pkg::OP_OR: r = {1'b0, d | s};
			default: begin
				w = c == alu_pkg::OP_WORD_ADD_IMMEDIATE ? {1'b0, h, d} + s : {1'b0, h, d} - s;
				fl[3] = c == alu_pkg::OP_WORD_ADD_IMMEDIATE ? !h[7] && w[15] : h[7] && !w[15];
				fl[4] = w[15] ^ fl[3];
				fl[2:0] = {w[15], w[15:0] == 16'h0000, w[16]};
			end
		endcase
		if (c inside {alu_pkg::OP_AND, alu_pkg::OP_OR}) fl[3] = 1'b0;
		else if (!wd) {fl[5], fl[0]} = {hn[4], r[8]};
		if (!wd) fl[2:1] = {r[7], r[7:0] == 8'h00};
		@(negedge clk);
		chk(busy === wd, "busy flag");
		// opValid stays high while busy and must be ignored
		if (wd) @(negedge clk);
		chk(resValid === 1'b1 && resWord === wd && flags === fl
			&& (wd ? {resHigh, resLow} === w[15:0] : resLow === r[7:0]), "op result");
	endtask
	task automatic io(alu_pkg::alu_io_op_t o, logic [7:0] a, logic [2:0] b, logic [7:0] d,
		logic e, logic [7:0] rd, logic sk);
		ioValid = 1'b1;
		ioOp = o;
		ioAddr = a;
		ioBit = b;
		ioWrData = d;
		@(negedge clk);
		chk(ioError === e && ioSkip === sk
			&& (e || !(o inside {alu_pkg::IO_IN, alu_pkg::IO_DATA_SPACE_LOAD}) || ioRdData === rd),
			"io access");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		op(alu_pkg::OP_ADD, 8'hff, 8'h01, 8'h00);
		op(alu_pkg::OP_ADD_CARRY, 8'h7f, 8'h00, 8'h00);
		op(alu_pkg::OP_SUB, 8'h00, 8'h01, 8'h00);
		op(alu_pkg::OP_SUBTRACT_WITH_CARRY, 8'h10, 8'h01, 8'h00);
		op(alu_pkg::OP_WORD_ADD_IMMEDIATE, 8'hff, 8'h01, 8'h7f);
		op(alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h01, 8'h00);
		op(alu_pkg::OP_AND, 8'hf0, 8'h3c, 8'h00);
		op(alu_pkg::OP_OR, 8'h00, 8'h00, 8'h00);
		opValid = 1'b0;
		io(alu_pkg::IO_OUT, 8'h05, 3'h0, 8'h81, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_BIT_SET, 8'h05, 3'h2, 8'h00, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_DATA_SPACE_LOAD, 8'h25, 3'h0, 8'h00, 1'b0, 8'h84, 1'b0);
		io(alu_pkg::IO_OUT, 8'h05, 3'h0, 8'h85, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h05, 3'h0, 8'h00, 1'b0, 8'h84, 1'b0);
		io(alu_pkg::IO_SKIP_IF_SET, 8'h05, 3'h2, 8'h00, 1'b0, 8'h00, 1'b1);
		io(alu_pkg::IO_SKIP_IF_CLEAR, 8'h05, 3'h2, 8'h00, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_BIT_CLEAR, 8'h05, 3'h2, 8'h00, 1'b0, 8'h00, 1'b0);
		ioValid = 1'b0;
		hwPulse = 1'b1;
		@(negedge clk);
		hwPulse = 1'b0;
		io(alu_pkg::IO_IN, 8'h05, 3'h0, 8'h00, 1'b0, 8'h81, 1'b0);
		io(alu_pkg::IO_BIT_SET, 8'h05, 3'h2, 8'h00, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h05, 3'h0, 8'h00, 1'b0, 8'h85, 1'b0);
		io(alu_pkg::IO_OUT, 8'h05, 3'h0, 8'h84, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h05, 3'h0, 8'h00, 1'b0, 8'h85, 1'b0);
		io(alu_pkg::IO_OUT, 8'h05, 3'h0, 8'h85, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h05, 3'h0, 8'h00, 1'b0, 8'h84, 1'b0);
		// hardware set and software clear in one cycle: set wins
		hwPulse = 1'b1;
		io(alu_pkg::IO_OUT, 8'h05, 3'h0, 8'h85, 1'b0, 8'h00, 1'b0);
		hwPulse = 1'b0;
		io(alu_pkg::IO_IN, 8'h05, 3'h0, 8'h00, 1'b0, 8'h85, 1'b0);
		io(alu_pkg::IO_DATA_SPACE_STORE, 8'h26, 3'h0, 8'h5a, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h06, 3'h0, 8'h00, 1'b0, 8'h5a, 1'b0);
		io(alu_pkg::IO_BIT_SET, 8'h20, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0);
		io(alu_pkg::IO_OUT, 8'h40, 3'h0, 8'hff, 1'b1, 8'h00, 1'b0);
		io(alu_pkg::IO_DATA_SPACE_STORE, 8'h1f, 3'h0, 8'hff, 1'b1, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h3f, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_IN, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0);
		io(alu_pkg::IO_DATA_SPACE_LOAD, 8'h1f, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0);
		io(alu_pkg::IO_DATA_SPACE_LOAD, 8'h60, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0);
		ioValid = 1'b0;
		// reset in mid-run: state and io registers back to reset values
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk(flags === alu_pkg::FLAGS_RESET && resValid === 1'b0 && busy === 1'b0, "reset state");
		io(alu_pkg::IO_IN, 8'h06, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0);
		ioValid = 1'b0;
		complete_run();
	end
endmodule
`default_nettype wire
